/* File: core/sib_blinker.sv */
/*
 * Blink pattern generator: a free-running period counter with a duty compare.
 * Assumes period and on time are stable while enabled; a period change restarts it.
 */
`timescale 1ns/1ns
module sib_blinker
   import sib_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             enable,
   input  wire logic [CNT_W-1:0] period_cyc,
   input  wire logic [CNT_W-1:0] on_cyc,
   output logic                  blink
);

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [CNT_W-1:0] period_ff;
   logic             wrap;
   logic             restart;

   assign restart = !enable || (period_cyc != period_ff);
   assign wrap    = (cnt_ff == period_cyc - CNT_W'(1));
   assign nxt_cnt = (restart || wrap) ? '0 : cnt_ff + CNT_W'(1);
   assign blink   = enable && (cnt_ff < on_cyc);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_ff    <= '0;
         period_ff <= '0;
      end else begin
         cnt_ff    <= nxt_cnt;
         period_ff <= period_cyc;
      end
   end

endmodule

/* File: core/sib_pkg.sv */
/*
 * Shared constants and types for the status indicator and boot strap block.
 * Assumes a free-running 20 MHz clock and a synchronous active-low reset.
 */
package sib_pkg;

   localparam int unsigned CLK_HZ = 20_000_000;

   // Blink timings in milliseconds, turned into clock cycles below.
   localparam int unsigned FAST_PERIOD_MS = 1000;
   localparam int unsigned FAST_ON_MS     = 500;
   localparam int unsigned SLOW_PERIOD_MS = 3000;
   localparam int unsigned SLOW_ON_MS     = 300;

   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * CYC_PER_MS;
   localparam int unsigned FAST_ON_CYC     = FAST_ON_MS * CYC_PER_MS;
   localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CYC_PER_MS;
   localparam int unsigned SLOW_ON_CYC     = SLOW_ON_MS * CYC_PER_MS;

   localparam int unsigned CNT_W = 26;
   localparam int unsigned TEMP_W = 8;

   // Edges after reset release before the strap synchronisers show pins.
   localparam logic [1:0]  SYNC_FILL = 2'h2;

   typedef enum logic [2:0] {
      SIB_ST_OFF        = 3'h0,
      SIB_ST_SEARCH     = 3'h1,
      SIB_ST_UNREG      = 3'h2,
      SIB_ST_TURN_OFF   = 3'h3,
      SIB_ST_REGISTERED = 3'h4,
      SIB_ST_CALL       = 3'h5
   } sib_dev_state_t;

   typedef enum logic [1:0] {
      SIB_BOOT_NORMAL   = 2'h0,
      SIB_BOOT_FAST     = 2'h1,
      SIB_BOOT_RECOVERY = 2'h2
   } sib_boot_mode_t;

   typedef struct packed {
      logic                mon_enable;
      logic                limit_valid;
      logic [TEMP_W-1:0]   limit;
   } sib_temp_cfg_t;

endpackage

/* File: core/sib_status_boot.sv */
/*
 * Status indicator driver, temperature alarm output and boot strap capture.
 * Assumes strap pins and the temperature reading come from outside the
 * clock domain; device state and settings come from same-clock logic.
 */
`timescale 1ns/1ns
module sib_status_boot
   import sib_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire sib_dev_state_t    dev_state,
   input  wire sib_temp_cfg_t     temp_cfg,
   input  wire logic [TEMP_W-1:0] temp_in,
   input  wire logic              fast_boot_strap_in,
   input  wire logic              recovery_boot_strap_in,
   output logic                   status_indicator_out,
   output logic                   temp_alarm_out,
   output sib_boot_mode_t         boot_mode,
   output logic                   boot_mode_valid
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for pin inputs.

   logic [1:0]        fast_sync_ff;
   logic [1:0]        rec_sync_ff;
   logic [TEMP_W-1:0] temp_s1_ff;
   logic [TEMP_W-1:0] temp_s2_ff;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fast_sync_ff <= 2'h0;
         rec_sync_ff  <= 2'h0;
         temp_s1_ff   <= '0;
         temp_s2_ff   <= '0;
      end else begin
         fast_sync_ff <= {fast_sync_ff[0], fast_boot_strap_in};
         rec_sync_ff  <= {rec_sync_ff[0], recovery_boot_strap_in};
         temp_s1_ff   <= temp_in;
         temp_s2_ff   <= temp_s1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status indicator.

   logic             fast_sel;
   logic             slow_sel;
   logic             blink_en;
   logic [CNT_W-1:0] period_sel;
   logic [CNT_W-1:0] on_sel;
   logic             blink;
   logic             nxt_led;
   logic             led_ff;

   assign fast_sel = (dev_state == SIB_ST_SEARCH) ||
                     (dev_state == SIB_ST_UNREG) ||
                     (dev_state == SIB_ST_TURN_OFF);
   assign slow_sel = (dev_state == SIB_ST_REGISTERED);
   assign blink_en = fast_sel || slow_sel;
   assign period_sel = fast_sel ? CNT_W'(FAST_PERIOD_CYC)
                                : CNT_W'(SLOW_PERIOD_CYC);
   assign on_sel     = fast_sel ? CNT_W'(FAST_ON_CYC)
                                : CNT_W'(SLOW_ON_CYC);
   // Call steady on, everything else not blinking steady off.
   assign nxt_led = (dev_state == SIB_ST_CALL) ? 1'h1 : blink;

   sib_blinker u_blinker (
      .clk        (clk),
      .resetn     (resetn),
      .enable     (blink_en),
      .period_cyc (period_sel),
      .on_cyc     (on_sel),
      .blink      (blink)
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         led_ff <= 1'h0;
      end else begin
         led_ff <= nxt_led;
      end
   end

   assign status_indicator_out = led_ff;

   ////////////////////////////////////////////////////////////////////////
   // Temperature alarm. The reading is synchronised per bit, so a word
   // caught mid-change can arrive torn. A value is only taken once two
   // samples in a row agree; this costs two cycles of alarm latency.

   logic [TEMP_W-1:0] temp_s3_ff;
   logic [TEMP_W-1:0] temp_ok_ff;
   logic [TEMP_W-1:0] nxt_temp_ok;
   logic              temp_agree;
   logic              alarm_ff;
   logic              nxt_alarm;

   assign temp_agree  = (temp_s2_ff == temp_s3_ff);
   assign nxt_temp_ok = temp_agree ? temp_s2_ff : temp_ok_ff;
   assign nxt_alarm   = temp_cfg.mon_enable && temp_cfg.limit_valid &&
                        (temp_ok_ff >= temp_cfg.limit);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         temp_s3_ff <= '0;
         temp_ok_ff <= '0;
         alarm_ff   <= 1'h0;
      end else begin
         temp_s3_ff <= temp_s2_ff;
         temp_ok_ff <= nxt_temp_ok;
         alarm_ff   <= nxt_alarm;
      end
   end

   assign temp_alarm_out = alarm_ff;

   ////////////////////////////////////////////////////////////////////////
   // Boot strap capture. Sampling waits until the synchronisers have
   // filled after reset, so the capture sees real pin levels.

   logic [1:0]     wait_ff;
   logic           captured_ff;
   sib_boot_mode_t mode_ff;
   sib_boot_mode_t nxt_mode;
   logic           take;

   assign take = !captured_ff && (wait_ff == SYNC_FILL);
   assign nxt_mode = rec_sync_ff[1]  ? SIB_BOOT_RECOVERY :
                     fast_sync_ff[1] ? SIB_BOOT_FAST :
                                       SIB_BOOT_NORMAL;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wait_ff     <= 2'h0;
         captured_ff <= 1'h0;
         mode_ff     <= SIB_BOOT_NORMAL;
      end else begin
         if (wait_ff != SYNC_FILL) begin
            wait_ff <= wait_ff + 2'h1;
         end
         if (take) begin
            captured_ff <= 1'h1;
            mode_ff     <= nxt_mode;
         end
      end
   end

   assign boot_mode       = mode_ff;
   assign boot_mode_valid = captured_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   a_call_steady_on: assert property (
      @(posedge clk) disable iff (!resetn)
      dev_state == SIB_ST_CALL |=> status_indicator_out)
      else $error("indicator not on during call");

   a_off_steady_off: assert property (
      @(posedge clk) disable iff (!resetn)
      dev_state == SIB_ST_OFF |=> !status_indicator_out)
      else $error("indicator not off while device off");

   a_unknown_state_off: assert property (
      @(posedge clk) disable iff (!resetn)
      dev_state > SIB_ST_CALL |=> !status_indicator_out)
      else $error("indicator not off for unknown state");

   a_fast_on_start: assert property (
      @(posedge clk) disable iff (!resetn)
      fast_sel && $past(!fast_sel) |=> ##1 status_indicator_out)
      else $error("fast blink does not start on");

   a_slow_on_start: assert property (
      @(posedge clk) disable iff (!resetn)
      slow_sel && $past(!slow_sel) |=> ##1 status_indicator_out)
      else $error("slow blink does not start on");

   a_alarm_follows: assert property (
      @(posedge clk) disable iff (!resetn)
      nxt_alarm |=> temp_alarm_out)
      else $error("temperature alarm not raised");

   a_alarm_disabled: assert property (
      @(posedge clk) disable iff (!resetn)
      !temp_cfg.mon_enable |=> !temp_alarm_out)
      else $error("alarm raised while monitor disabled");

   a_no_limit_quiet: assert property (
      @(posedge clk) disable iff (!resetn)
      !temp_cfg.limit_valid |=> !temp_alarm_out)
      else $error("alarm raised without a valid limit");

   a_reading_held: assert property (
      @(posedge clk) disable iff (!resetn)
      !temp_agree |=> $stable(temp_ok_ff))
      else $error("unsettled reading reached the compare");

   a_recovery_wins: assert property (
      @(posedge clk) disable iff (!resetn)
      take && rec_sync_ff[1] |=> boot_mode == SIB_BOOT_RECOVERY)
      else $error("recovery strap not honoured");

   a_fast_boot: assert property (
      @(posedge clk) disable iff (!resetn)
      take && fast_sync_ff[1] && !rec_sync_ff[1]
      |=> boot_mode == SIB_BOOT_FAST)
      else $error("fast boot strap not honoured");

   a_normal_boot: assert property (
      @(posedge clk) disable iff (!resetn)
      take && !fast_sync_ff[1] && !rec_sync_ff[1]
      |=> boot_mode == SIB_BOOT_NORMAL)
      else $error("normal boot not selected without straps");

   a_mode_frozen: assert property (
      @(posedge clk) disable iff (!resetn)
      boot_mode_valid |=> $stable(boot_mode) && boot_mode_valid)
      else $error("boot mode changed after capture");

   a_no_early_valid: assert property (
      @(posedge clk) disable iff (!resetn)
      !captured_ff && wait_ff != SYNC_FILL |=> !boot_mode_valid)
      else $error("boot mode valid before straps settled");

   a_valid_from_take: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(boot_mode_valid) |-> $past(take))
      else $error("boot mode valid without a capture");

endmodule

/* File: test/sib_board_model.sv */
/*
 * Board side of the block: strap drivers and the indicator load.
 * Assumes the bench says when the board is in its boot window.
 */
`timescale 1ns/1ns
module sib_board_model
   import sib_pkg::*;
(
   input  wire logic booting,
   input  wire logic fast_req,
   input  wire logic rec_req,
   input  wire logic status_indicator_out,
   output logic      fast_boot_strap_in,
   output logic      recovery_boot_strap_in
);
   // After boot the board reuses the pins, so they show the inverse level.
   assign fast_boot_strap_in     = booting ? fast_req : !fast_req;
   assign recovery_boot_strap_in = booting ? rec_req : !rec_req;
endmodule

/* File: test/sib_status_boot_test.sv */
/*
 * Self-checking bench for the status indicator and boot strap block.
 * Assumes the package counts; only early blink cycles fit in one run.
 */
`timescale 1ns/1ns
module sib_status_boot_test
   import sib_pkg::*;
;
   logic              clk = 0;
   logic              resetn = 0;
   logic              booting = 1;
   logic              fast_req = 0;
   logic              rec_req = 0;
   sib_dev_state_t    dev_state = SIB_ST_OFF;
   sib_temp_cfg_t     temp_cfg = '0;
   logic [TEMP_W-1:0] temp_in = '0;
   logic              fast_s, rec_s, led, alarm, mode_vld;
   sib_boot_mode_t    boot_mode;
   int                errors = 0;
   int                n_tests = 0;
   int                i, k, per, on, ex;

   sib_status_boot sib_status_boot_i (.clk(clk), .resetn(resetn),
      .dev_state(dev_state), .temp_cfg(temp_cfg), .temp_in(temp_in),
      .fast_boot_strap_in(fast_s), .recovery_boot_strap_in(rec_s),
      .status_indicator_out(led), .temp_alarm_out(alarm),
      .boot_mode(boot_mode), .boot_mode_valid(mode_vld));
   sib_board_model sib_board_model_i (.booting(booting),
      .fast_req(fast_req), .rec_req(rec_req), .status_indicator_out(led),
      .fast_boot_strap_in(fast_s), .recovery_boot_strap_in(rec_s));

   ////////////////////////////////////////////////////////////////////////
   initial forever #25 clk = ~clk;

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Straps are held through the capture, then the board flips them.
   task automatic boot(input logic f, input logic r);
      fast_req = f;
      rec_req = r;
      booting = 1;
      resetn = 0;
      tick(16);
      chk(mode_vld, 0);
      resetn = 1;
      for (k = 0; k < 8 && mode_vld !== 1'b1; k++) tick(1);
      if (k == 8) begin
         errors++;
         close_out;
      end
      tick(2);
      booting = 0;
      ex = r ? 2 : (f ? 1 : 0);
      chk(boot_mode, ex);
      tick(6);
      chk({mode_vld, boot_mode}, {1'b1, ex[1:0]});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      k = $urandom(4323);
      for (i = 0; i < 4; i++) boot(i[0], i[1]);
      $display("Boot strap test done");
      // States run in code order, so shutting down goes straight to slow.
      for (i = 0; i < 8; i++) begin
         dev_state = sib_dev_state_t'(i[2:0]);
         per = 0;
         on = 0;
         if (i >= 1 && i <= 3) begin
            per = FAST_PERIOD_CYC;
            on = FAST_ON_CYC;
         end
         if (i == 4) begin
            per = SLOW_PERIOD_CYC;
            on = SLOW_ON_CYC;
         end
         tick(2);
         for (k = 2; k < 300; k++) begin
            ex = (i == 5) ? 1 : (per == 0 ? 0 : int'((k - 2) % per < on));
            chk(led, ex);
            tick(1);
         end
      end
      $display("Status indicator test done");
      for (i = 0; i < 40; i++) begin
         temp_cfg = {1'($urandom), 1'($urandom), 8'($urandom)};
         temp_in = (i % 4 == 0) ? temp_cfg.limit : 8'($urandom);
         tick(5);
         ex = temp_cfg.mon_enable & temp_cfg.limit_valid &
              (temp_in >= temp_cfg.limit);
         chk(alarm, ex);
      end
      $display("Temperature alarm test done");
      close_out;
   end
endmodule
